/* rtl/pfb_pkg.sv */
// Behaviour
// - osc fail sets bank two bit 7
// - bank two bits 6..4 read zero
// - bus collision sets bank two bit 3
// - low voltage sets bank two bit 2
// - timer 3 rollover sets bank two bit 1
// - timer 3 gate sets bank two bit 0
// - rx flag mirrors receive buffer full
// - tx flag mirrors transmit buffer empty
// - charge time event sets bank three bit 3
// - capcmp 1/2 set on capture or compare
// - pulse width mode never sets capcmp flag
// - timer 4 overflow sets bank four bit 7
// - nvm write completion sets bank four bit 6
// - comparator events set bank four bits 5,4
// - capcmp 3..5 flags; bank four bit 3 zero
// - invalid CAN message sets bank five bit 7
// - CAN bus activity sets bank five bit 6
// - any CAN status error sets bit 5
// - CAN tx buffer done sets bits 4..2
// - bit 1 source depends on buffer mode
// - bit 0: rxbuf0, zero, or fifo level
// - flags set regardless of enables
// - peripheral enable gates all peripheral requests
package pfb_pkg;
   localparam logic [11:0] PFB_OFS_FLAGS2 = 12'h000;
   localparam logic [11:0] PFB_OFS_FLAGS3 = 12'h004;
   localparam logic [11:0] PFB_OFS_FLAGS4 = 12'h008;
   localparam logic [11:0] PFB_OFS_FLAGS5 = 12'h00C;
   localparam logic [11:0] PFB_OFS_EN2 = 12'h010;
   localparam logic [11:0] PFB_OFS_EN3 = 12'h014;
   localparam logic [11:0] PFB_OFS_EN4 = 12'h018;
   localparam logic [11:0] PFB_OFS_EN5 = 12'h01C;
   localparam logic [11:0] PFB_OFS_CTRL = 12'h020;
   // implemented-bit masks per bank
   localparam logic [7:0] PFB_MASK2 = 8'h8F;
   localparam logic [7:0] PFB_MASK3 = 8'h3E;
   localparam logic [7:0] PFB_MASK4 = 8'hF7;
   localparam logic [7:0] PFB_MASK5 = 8'hFF;
   // software-writable (clearable) bits; rx/tx serial are read-only
   localparam logic [7:0] PFB_SWMASK3 = 8'h0E;
   localparam logic [7:0] PFB_FLAG_RESET = 8'h00;
   localparam int PFB_SER_RX_BIT = 5;
   localparam int PFB_SER_TX_BIT = 4;
   localparam int PFB_CTRL_PEN_BIT = 0;
   localparam int PFB_CTRL_PRI_BIT = 1;
   localparam int PFB_CTRL_MODE_LSB = 2;
   localparam int PFB_CTRL_HF_BIT = 4;
   localparam logic [1:0] PFB_CCP_PWM = 2'h2;
   typedef enum logic [1:0] {
      PFB_MODE0 = 2'b00,
      PFB_MODE1 = 2'b01,
      PFB_MODE2 = 2'b10
   } pfb_canmode_t;
   typedef struct packed {
      logic osc_fail;
      logic bus_collision;
      logic low_voltage;
      logic timer3_rollover;
      logic timer3_gate;
      logic charge_time;
      logic timer4_overflow;
      logic nvm_write_done;
      logic comparator2;
      logic comparator1;
   } pfb_misc_ev_t;
   typedef struct packed {
      logic [4:0] event_hit;
      logic [9:0] mode;
   } pfb_capcmp_t;
   typedef struct packed {
      logic invalid_msg;
      logic bus_activity;
      logic [3:0] comm_status_err;
      logic [2:0] txbuf_done;
      logic rxbuf0_new;
      logic rxbuf1_new;
      logic any_rx_new;
      logic fifo_half;
      logic fifo_full;
   } pfb_can_ev_t;
endpackage

/* rtl/pfb_flag_bit.sv */
`timescale 1ns/1ps
module pfb_flag_bit (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic set_ev,
   input wire logic sw_clear,
   output logic flag_q
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
      end else if (set_ev) begin
         flag_q <= 1'b1;
      end else if (sw_clear) begin
         flag_q <= 1'b0;
      end
   end

   property p_set_wins;
      @(posedge pclk) disable iff (!presetn)
         set_ev |=> flag_q;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("flag lost an event");
endmodule

/* rtl/pfb_apb_slave.sv */
`timescale 1ns/1ps
module pfb_apb_slave (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] rd_word,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   output logic wr_stb,
   output logic rd_stb,
   output logic [11:0] acc_addr,
   output logic [7:0] wr_byte,
   input wire logic addr_ok
);
   // one wait state: pready rises one cycle into the access phase, registered
   logic acc;
   assign acc = psel && penable && !pready;
   assign wr_stb = acc && pwrite && addr_ok;
   assign rd_stb = acc && !pwrite && addr_ok;
   assign acc_addr = paddr;
   assign wr_byte = pwdata[7:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= acc;
         pslverr <= acc && !addr_ok;
         prdata <= (acc && !pwrite) ? rd_word : 32'h0000_0000;
      end
   end
endmodule

/* rtl/pfb_top.sv */
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
module pfb_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pfb_pkg::pfb_misc_ev_t misc_ev,
   input wire pfb_pkg::pfb_capcmp_t capcmp,
   input wire pfb_pkg::pfb_can_ev_t can_ev,
   input wire logic serial2_rx_full,
   input wire logic serial2_tx_empty,
   output logic periph_irq_q,
   output logic serial2_rx_buffer_rd,
   output logic serial2_tx_buffer_wr
);
   logic wr_stb;
   logic [11:0] acc_addr;
   logic [7:0] wr_byte;
   logic [31:0] rd_word;
   logic addr_ok;
   logic [7:0] en2_q, en3_q, en4_q, en5_q;
   logic [4:0] ctrl_q;
   logic [7:0] set2, set3, set4, set5;
   logic [7:0] clr2, clr3, clr4, clr5;
   logic [7:0] fl2, fl3, fl4, fl5;
   logic [7:0] rd2, rd3, rd4, rd5;
   logic [4:0] cc_ev;
   logic [3:0] can_err;
   pfb_pkg::pfb_canmode_t mode;

   pfb_apb_slave u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .rd_word(rd_word),
      .pready(pready),
      .pslverr(pslverr),
      .prdata(prdata),
      .wr_stb(wr_stb),
      .rd_stb(),
      .acc_addr(acc_addr),
      .wr_byte(wr_byte),
      .addr_ok(addr_ok)
   );

   assign mode = pfb_pkg::pfb_canmode_t'(
      ctrl_q[pfb_pkg::PFB_CTRL_MODE_LSB +: 2]);
   assign can_err = can_ev.comm_status_err;

   // pulse-width mode units never raise their flag
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_cc
         assign cc_ev[gi] = capcmp.event_hit[gi] &&
            (capcmp.mode[2*gi +: 2] != pfb_pkg::PFB_CCP_PWM);
      end
   endgenerate

   // events, sets always regardless of enables
   always_comb begin
      set2 = 8'h00;
      set3 = 8'h00;
      set4 = 8'h00;
      set5 = 8'h00;
      set2[7] = misc_ev.osc_fail;
      set2[3] = misc_ev.bus_collision;
      set2[2] = misc_ev.low_voltage;
      set2[1] = misc_ev.timer3_rollover;
      set2[0] = misc_ev.timer3_gate;
      set3[3] = misc_ev.charge_time;
      set3[2] = cc_ev[1];
      set3[1] = cc_ev[0];
      set4[7] = misc_ev.timer4_overflow;
      set4[6] = misc_ev.nvm_write_done;
      set4[5] = misc_ev.comparator2;
      set4[4] = misc_ev.comparator1;
      set4[2:0] = cc_ev[4:2];
      set5[7] = can_ev.invalid_msg;
      set5[6] = can_ev.bus_activity;
      set5[5] = |can_err;
      set5[4:2] = can_ev.txbuf_done;
      if (mode == pfb_pkg::PFB_MODE0) begin
         set5[1] = can_ev.rxbuf1_new;
         set5[0] = can_ev.rxbuf0_new;
      end else if (mode == pfb_pkg::PFB_MODE1) begin
         set5[1] = can_ev.any_rx_new;
         set5[0] = 1'b0;
      end else begin
         set5[1] = can_ev.any_rx_new;
         set5[0] = ctrl_q[pfb_pkg::PFB_CTRL_HF_BIT] ?
            can_ev.fifo_half : can_ev.fifo_full;
      end
   end

   // writing a zero clears a flag; writing a one leaves it alone
   always_comb begin
      clr2 = 8'h00;
      clr3 = 8'h00;
      clr4 = 8'h00;
      clr5 = 8'h00;
      if (wr_stb && acc_addr == pfb_pkg::PFB_OFS_FLAGS2) begin
         clr2 = ~wr_byte & pfb_pkg::PFB_MASK2;
      end else if (wr_stb && acc_addr == pfb_pkg::PFB_OFS_FLAGS3) begin
         clr3 = ~wr_byte & pfb_pkg::PFB_SWMASK3;
      end else if (wr_stb && acc_addr == pfb_pkg::PFB_OFS_FLAGS4) begin
         clr4 = ~wr_byte & pfb_pkg::PFB_MASK4;
      end else if (wr_stb && acc_addr == pfb_pkg::PFB_OFS_FLAGS5) begin
         clr5 = ~wr_byte & pfb_pkg::PFB_MASK5;
      end
   end

   genvar bi;
   generate
      for (bi = 0; bi < 8; bi++) begin : g_bit
         pfb_flag_bit u_f2 (.pclk(pclk), .presetn(presetn),
            .set_ev(set2[bi]), .sw_clear(clr2[bi]), .flag_q(fl2[bi]));
         pfb_flag_bit u_f3 (.pclk(pclk), .presetn(presetn),
            .set_ev(set3[bi]), .sw_clear(clr3[bi]), .flag_q(fl3[bi]));
         pfb_flag_bit u_f4 (.pclk(pclk), .presetn(presetn),
            .set_ev(set4[bi]), .sw_clear(clr4[bi]), .flag_q(fl4[bi]));
         pfb_flag_bit u_f5 (.pclk(pclk), .presetn(presetn),
            .set_ev(set5[bi]), .sw_clear(clr5[bi]), .flag_q(fl5[bi]));
      end
   endgenerate

   // visible values; unimplemented bits forced to zero
   always_comb begin
      rd2 = fl2 & pfb_pkg::PFB_MASK2;
      rd3 = fl3 & pfb_pkg::PFB_SWMASK3;
      rd3[pfb_pkg::PFB_SER_RX_BIT] = serial2_rx_full;
      rd3[pfb_pkg::PFB_SER_TX_BIT] = serial2_tx_empty;
      rd4 = fl4 & pfb_pkg::PFB_MASK4;
      rd5 = fl5;
      if (mode == pfb_pkg::PFB_MODE1) begin
         rd5[0] = 1'b0;
      end
   end

   always_comb begin
      addr_ok = 1'b1;
      rd_word = 32'h0000_0000;
      if (acc_addr == pfb_pkg::PFB_OFS_FLAGS2) begin
         rd_word[7:0] = rd2;
      end else if (acc_addr == pfb_pkg::PFB_OFS_FLAGS3) begin
         rd_word[7:0] = rd3;
      end else if (acc_addr == pfb_pkg::PFB_OFS_FLAGS4) begin
         rd_word[7:0] = rd4;
      end else if (acc_addr == pfb_pkg::PFB_OFS_FLAGS5) begin
         rd_word[7:0] = rd5;
      end else if (acc_addr == pfb_pkg::PFB_OFS_EN2) begin
         rd_word[7:0] = en2_q;
      end else if (acc_addr == pfb_pkg::PFB_OFS_EN3) begin
         rd_word[7:0] = en3_q;
      end else if (acc_addr == pfb_pkg::PFB_OFS_EN4) begin
         rd_word[7:0] = en4_q;
      end else if (acc_addr == pfb_pkg::PFB_OFS_EN5) begin
         rd_word[7:0] = en5_q;
      end else if (acc_addr == pfb_pkg::PFB_OFS_CTRL) begin
         rd_word[4:0] = ctrl_q;
      end else begin
         addr_ok = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en2_q <= pfb_pkg::PFB_FLAG_RESET;
         en3_q <= pfb_pkg::PFB_FLAG_RESET;
         en4_q <= pfb_pkg::PFB_FLAG_RESET;
         en5_q <= pfb_pkg::PFB_FLAG_RESET;
         ctrl_q <= 5'h00;
      end else if (wr_stb) begin
         if (acc_addr == pfb_pkg::PFB_OFS_EN2) begin
            en2_q <= wr_byte & pfb_pkg::PFB_MASK2;
         end else if (acc_addr == pfb_pkg::PFB_OFS_EN3) begin
            en3_q <= wr_byte & pfb_pkg::PFB_MASK3;
         end else if (acc_addr == pfb_pkg::PFB_OFS_EN4) begin
            en4_q <= wr_byte & pfb_pkg::PFB_MASK4;
         end else if (acc_addr == pfb_pkg::PFB_OFS_EN5) begin
            en5_q <= wr_byte;
         end else if (acc_addr == pfb_pkg::PFB_OFS_CTRL) begin
            ctrl_q <= wr_byte[4:0];
         end
      end
   end

   // serial2 buffer strobes are held low; flag-bank three accesses have no buffer side effects
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial2_rx_buffer_rd <= 1'b0;
         serial2_tx_buffer_wr <= 1'b0;
      end else begin
         serial2_rx_buffer_rd <= 1'b0;
         serial2_tx_buffer_wr <= 1'b0;
      end
   end

   // priority mode holds periph_irq_q low; only the flat path here
   logic any_req;
   assign any_req = |(rd2 & en2_q) | |(rd3 & en3_q) |
      |(rd4 & en4_q) | |(rd5 & en5_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_irq_q <= 1'b0;
      end else begin
         periph_irq_q <= any_req &&
            ctrl_q[pfb_pkg::PFB_CTRL_PEN_BIT] &&
            !ctrl_q[pfb_pkg::PFB_CTRL_PRI_BIT];
      end
   end

   property p_irq_gate;
      @(posedge pclk) disable iff (!presetn)
         !ctrl_q[pfb_pkg::PFB_CTRL_PEN_BIT] |=> !periph_irq_q;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("irq raised with peripheral enable low");

   property p_irq_or;
      @(posedge pclk) disable iff (!presetn)
         (any_req && ctrl_q[pfb_pkg::PFB_CTRL_PEN_BIT] &&
          !ctrl_q[pfb_pkg::PFB_CTRL_PRI_BIT]) |=> periph_irq_q;
   endproperty
   a_irq_or: assert property (p_irq_or)
      else $error("enabled flag did not raise irq");

   property p_unimpl2;
      @(posedge pclk) disable iff (!presetn)
         rd2[6:4] == 3'h0;
   endproperty
   a_unimpl2: assert property (p_unimpl2)
      else $error("bank two reserved bits nonzero");

   property p_unimpl4;
      @(posedge pclk) disable iff (!presetn)
         rd4[3] == 1'b0;
   endproperty
   a_unimpl4: assert property (p_unimpl4)
      else $error("bank four bit 3 nonzero");

   property p_osc;
      @(posedge pclk) disable iff (!presetn)
         misc_ev.osc_fail |=> rd2[7];
   endproperty
   a_osc: assert property (p_osc)
      else $error("osc fail flag not set");

   property p_pwm;
      @(posedge pclk) disable iff (!presetn)
         (capcmp.mode[1:0] == pfb_pkg::PFB_CCP_PWM && !rd3[1] &&
          capcmp.event_hit[0]) |=> !rd3[1];
   endproperty
   a_pwm: assert property (p_pwm)
      else $error("pwm mode set capcmp1 flag");

   property p_mode1;
      @(posedge pclk) disable iff (!presetn)
         mode == pfb_pkg::PFB_MODE1 |-> rd5[0] == 1'b0;
   endproperty
   a_mode1: assert property (p_mode1)
      else $error("bank five bit 0 nonzero in mode 1");

   property p_rx;
      @(posedge pclk) disable iff (!presetn)
         rd3[pfb_pkg::PFB_SER_RX_BIT] == serial2_rx_full;
   endproperty
   a_rx: assert property (p_rx)
      else $error("rx flag does not follow buffer");

   property p_canerr;
      @(posedge pclk) disable iff (!presetn)
         (|can_err) |=> rd5[5];
   endproperty
   a_canerr: assert property (p_canerr)
      else $error("can error flag not set");

   property p_tx;
      @(posedge pclk) disable iff (!presetn)
         rd3[pfb_pkg::PFB_SER_TX_BIT] == serial2_tx_empty;
   endproperty
   a_tx: assert property (p_tx)
      else $error("tx flag does not follow buffer");

   // only a software zero may drop a latched flag
   property p_keep;
      @(posedge pclk) disable iff (!presetn)
         (rd2[3] && !clr2[3]) |=> rd2[3];
   endproperty
   a_keep: assert property (p_keep)
      else $error("bus collision flag dropped without clear");

   property p_lowv;
      @(posedge pclk) disable iff (!presetn)
         misc_ev.low_voltage |=> rd2[2];
   endproperty
   a_lowv: assert property (p_lowv)
      else $error("low voltage flag not set");

   property p_t4;
      @(posedge pclk) disable iff (!presetn)
         misc_ev.timer4_overflow |=> rd4[7];
   endproperty
   a_t4: assert property (p_t4)
      else $error("timer 4 flag not set");

   property p_nvm;
      @(posedge pclk) disable iff (!presetn)
         misc_ev.nvm_write_done |=> rd4[6];
   endproperty
   a_nvm: assert property (p_nvm)
      else $error("nvm write flag not set");

   property p_inv;
      @(posedge pclk) disable iff (!presetn)
         can_ev.invalid_msg |=> rd5[7];
   endproperty
   a_inv: assert property (p_inv)
      else $error("invalid message flag not set");

   property p_pwm3;
      @(posedge pclk) disable iff (!presetn)
         (capcmp.mode[5:4] == pfb_pkg::PFB_CCP_PWM && !rd4[0] &&
          capcmp.event_hit[2]) |=> !rd4[0];
   endproperty
   a_pwm3: assert property (p_pwm3)
      else $error("pwm mode set capcmp3 flag");

   c_irq: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(periph_irq_q));
   c_clear: cover property (@(posedge pclk) disable iff (!presetn)
      rd2[3] ##1 !rd2[3]);
   c_mode2: cover property (@(posedge pclk) disable iff (!presetn)
      mode == pfb_pkg::PFB_MODE2 && rd5[0]);
endmodule

/* testbench/pfb_periph_model.sv */
`timescale 1ns/1ps
module pfb_periph_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [28:0] ev_flat,
   input wire logic [9:0] ccp_mode,
   input wire logic rx_set,
   input wire logic rx_take,
   input wire logic tx_free,
   input wire logic tx_fill,
   input wire logic serial2_rx_buffer_rd,
   input wire logic serial2_tx_buffer_wr,
   output pfb_pkg::pfb_misc_ev_t misc_ev,
   output pfb_pkg::pfb_capcmp_t capcmp,
   output pfb_pkg::pfb_can_ev_t can_ev,
   output logic serial2_rx_full,
   output logic serial2_tx_empty
);
   assign misc_ev = ev_flat[28:19];
   assign capcmp = {ev_flat[18:14], ccp_mode};
   assign can_ev = ev_flat[13:0];
   // buffer state lives here; the flag bank only mirrors it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         serial2_rx_full <= 1'b0;
      else if (rx_set)
         serial2_rx_full <= 1'b1;
      else if (rx_take || serial2_rx_buffer_rd)
         serial2_rx_full <= 1'b0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         serial2_tx_empty <= 1'b0;
      else if (tx_fill || serial2_tx_buffer_wr)
         serial2_tx_empty <= 1'b0;
      else if (tx_free)
         serial2_tx_empty <= 1'b1;
   end
endmodule

/* testbench/peripheral_flag_bank_tb.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin \
   n_checks++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); \
   end \
end
module peripheral_flag_bank_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, periph_irq_q;
   logic serial2_rx_buffer_rd, serial2_tx_buffer_wr;
   logic serial2_rx_full, serial2_tx_empty;
   pfb_pkg::pfb_misc_ev_t misc_ev;
   pfb_pkg::pfb_capcmp_t capcmp;
   pfb_pkg::pfb_can_ev_t can_ev;
   logic [28:0] ev_flat = '0;
   logic [9:0] ccp_mode = '0;
   logic rx_set = 1'b0, rx_take = 1'b0, tx_free = 1'b0, tx_fill = 1'b0;
   int fail_count = 0;
   int n_checks = 0;
   logic [33:0] expq[$];
   logic [7:0] expf[4];
   logic [7:0] sw[4];
   logic [31:0] rnd = 32'hE7F4;
   int md = 0;
   logic hf = 1'b0, rxl = 1'b0, txl = 1'b0;

   pfb_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .misc_ev, .capcmp, .can_ev,
      .serial2_rx_full, .serial2_tx_empty, .periph_irq_q,
      .serial2_rx_buffer_rd, .serial2_tx_buffer_wr);
   pfb_periph_model model (.pclk, .presetn, .ev_flat, .ccp_mode, .rx_set,
      .rx_take, .tx_free, .tx_fill, .serial2_rx_buffer_rd,
      .serial2_tx_buffer_wr, .misc_ev, .capcmp, .can_ev,
      .serial2_rx_full, .serial2_tx_empty);

   initial begin
      forever #2.5 pclk = ~pclk;
   end

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // bank*8+bit that event line i should set, -1 for none
   function automatic int evmap(input int i);
      int u;
      u = i - 14;
      if (i >= 19)
         return i == 28 ? 7 : i >= 24 ? i - 24 : i == 23 ? 11 : i + 1;
      if (i >= 14)
         return ccp_mode[2*u +: 2] == 2'h2 ? -1 : u < 2 ? 9 + u : 14 + u;
      if (i >= 12)
         return i + 18;
      if (i >= 8)
         return 29;
      if (i >= 5)
         return i + 21;
      if (i == 4)
         return md == 0 ? 24 : -1;
      if (i == 3)
         return md == 0 ? 25 : -1;
      if (i == 2)
         return md == 0 ? -1 : 25;
      if (i == 1)
         return (md == 2 && hf) ? 24 : -1;
      return (md == 2 && !hf) ? 24 : -1;
   endfunction

   task automatic xfer(input logic w, input logic [11:0] a,
         input logic [31:0] d, input logic cd, input logic [32:0] e);
      int n;
      n = 0;
      expq.push_back({cd, e});
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16)
         fail_count++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 1'b0, 33'h0);
   endtask

   function automatic logic [11:0] ofs(input int b);
      return pfb_pkg::PFB_OFS_FLAGS2 + 12'(4 * b);
   endfunction

   task automatic rd_all;
      for (int b = 0; b < 4; b++)
         xfer(1'b0, ofs(b), 32'h0, 1'b1, {25'h0, expf[b] |
            (b == 1 ? {2'b00, rxl, txl, 4'h0} : 8'h00)});
   endtask

   // zero bits clear, ones and unimplemented bits must stay put
   task automatic clr(input logic rz);
      logic [7:0] w;
      for (int b = 0; b < 4; b++) begin
         rnd = nxt(rnd);
         w = rz ? rnd[7:0] : 8'h00;
         wr(ofs(b), {rnd[31:8], w});
         expf[b] = expf[b] & (~sw[b] | w);
      end
   endtask

   task automatic pulse(input int i);
      int c;
      @(posedge pclk);
      ev_flat <= 29'(1) << i;
      @(posedge pclk);
      ev_flat <= '0;
      c = evmap(i);
      if (c >= 0)
         expf[c / 8][c % 8] = 1'b1;
   endtask

   task automatic ctrl(input logic pen, input logic pri);
      wr(pfb_pkg::PFB_OFS_CTRL, {27'h0, hf, 2'(md), pri, pen});
   endtask

   task automatic chk_irq(input logic e);
      repeat (2) @(posedge pclk);
      `CHK(periph_irq_q, e)
      `CHK({serial2_rx_buffer_rd, serial2_tx_buffer_wr}, 2'b00)
   endtask

   task final_report;
      if (fail_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge pclk) begin
      logic [33:0] e;
      if (psel && penable && pready === 1'b1) begin
         e = expq.pop_front();
         `CHK(pslverr, e[32])
         if (e[33])
            `CHK(prdata, e[31:0])
      end
   end

   initial begin
      #100000;
      fail_count++;
      final_report;
   end

   initial begin
      logic [9:0] cm;
      sw = '{pfb_pkg::PFB_MASK2, pfb_pkg::PFB_SWMASK3,
         pfb_pkg::PFB_MASK4, pfb_pkg::PFB_MASK5};
      expf = '{default: 8'h00};
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd_all;
      xfer(1'b0, 12'h040, 32'h0, 1'b1, {1'b1, 32'h0});
      xfer(1'b1, 12'h044, 32'hFFFFFFFF, 1'b0, {1'b1, 32'h0});
      for (int p = 0; p < 4; p++) begin
         rnd = nxt(rnd);
         md = p == 0 ? 0 : p == 1 ? 1 : 2;
         hf = p == 3;
         cm = p == 1 ? 10'h2AA : p == 3 ? rnd[9:0] : 10'h000;
         ccp_mode <= cm;
         ctrl(1'b0, 1'b0);
         for (int i = 28; i >= 0; i--) begin
            pulse(i);
            rd_all;
         end
         clr(1'b1);
         rd_all;
         clr(1'b0);
      end
      // receive and transmit flags follow buffer state only
      @(posedge pclk);
      rx_set <= 1'b1;
      tx_free <= 1'b1;
      @(posedge pclk);
      rx_set <= 1'b0;
      tx_free <= 1'b0;
      rxl = 1'b1;
      txl = 1'b1;
      clr(1'b0);
      rd_all;
      @(posedge pclk);
      rx_take <= 1'b1;
      tx_fill <= 1'b1;
      @(posedge pclk);
      rx_take <= 1'b0;
      tx_fill <= 1'b0;
      rxl = 1'b0;
      txl = 1'b0;
      rd_all;
      pulse(28);
      wr(pfb_pkg::PFB_OFS_EN2, 32'h80);
      chk_irq(1'b0);
      ctrl(1'b1, 1'b0);
      chk_irq(1'b1);
      ctrl(1'b1, 1'b1);
      chk_irq(1'b0);
      ctrl(1'b1, 1'b0);
      wr(pfb_pkg::PFB_OFS_EN2, 32'h7F);
      chk_irq(1'b0);
      wr(pfb_pkg::PFB_OFS_EN2, 32'h80);
      chk_irq(1'b1);
      // a one-cycle event must survive a clear landing in the same cycle
      // one-cycle event on the very edge the clear is taken
      fork
         wr(ofs(0), 32'h0);
         begin
            repeat (2) @(posedge pclk);
            ev_flat <= 29'(1) << 27;
            @(posedge pclk);
            ev_flat <= '0;
         end
      join
      expf[0] = 8'h08;
      rd_all;
      chk_irq(1'b0);
      final_report;
   end
endmodule
